// ### design/l1_cache_maintenance_ops.sv
// Register front end and in-order issuer for L1 cache maintenance operations.
// Assumes the cache arrays take one command at a time and answer each with a done pulse.
`timescale 1ns/100ps

// Contract
// RULE_01 - Unprivileged access performs nothing and answers with a bus fault.
// RULE_02 - Write to instruction invalidate-all clears whole instruction cache; reads zero.
// RULE_03 - Branch predictor location reads zero and ignores writes.
// RULE_04 - By-address registers take a 32-bit address, are write-only, read zero.
// RULE_05 - Instruction line invalidate by address to point of unification.
// RULE_06 - Data line invalidate by address to point of coherency, no write-back.
// RULE_07 - Data line clean by address to unification or coherency point.
// RULE_08 - Data line clean then invalidate by address to point of coherency.
// RULE_09 - Set/way invalidate, clean and flush each act on one selected line.
// RULE_10 - Set index in bits 13:5; 29:14 and 4:1 reserved; bit 0 reads zero.
// RULE_11 - Way field in top bits accepts ways 0 to 3.
// RULE_12 - Smaller caches use the low-order bits of the set field.
// RULE_13 - Software sizes a whole-cache walk from the geometry registers.
// RULE_14 - Bits 16 and 17 of core control enable data and instruction caches.
// RULE_15 - Software invalidates each cache after reset before enabling it.
// RULE_16 - Software cleans the whole data cache before disabling it.
// RULE_17 - Software runs an instruction barrier after switching the instruction cache.
// RULE_18 - Maintenance faults are reported late, no hard fault when handled, no lockup.
// RULE_19 - Operations complete in issue order; one barrier covers them all.
// RULE_20 - Software places a data barrier before by-address or set/way operations.
// RULE_21 - A miss completes with no effect on contents and no fault.
module l1_cache_maintenance_ops #(
    parameter int QUEUE_DEPTH = 4,
    parameter int SET_BITS = 9
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire cache_maint_pkg::bus_req_s i_bus_req,
    output logic o_bus_ready,
    output cache_maint_pkg::bus_rsp_s o_bus_rsp,
    output logic o_cmd_valid,
    output cache_maint_pkg::cache_cmd_s o_cmd,
    input wire logic i_cmd_ready,
    input wire logic i_cmd_done,
    input wire logic i_cmd_error,
    input wire logic i_bus_fault_handler_en,
    output logic o_bus_fault_a,
    output logic o_hard_fault_b,
    output logic o_ops_drained,
    output logic o_dcache_enable,
    output logic o_icache_enable
);

    localparam int AW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
    localparam int QW = $bits(cache_maint_pkg::queued_op_s);
    localparam logic [AW:0] DEPTH_COUNT = (AW + 1)'(QUEUE_DEPTH);
    localparam int SET_W = cache_maint_pkg::SET_FIELD_BITS;
    localparam logic [SET_W-1:0] SET_MASK = SET_W'((1 << SET_BITS) - 1);

    // Refuse shapes the pointer logic and set field cannot serve
    if (QUEUE_DEPTH < 2 || (1 << AW) != QUEUE_DEPTH) begin : g_bad_depth
        $error("QUEUE_DEPTH must be a power of two of at least 2");
    end
    if (SET_BITS < 1 || SET_BITS > cache_maint_pkg::SET_FIELD_BITS) begin : g_bad_sets
        $error("SET_BITS must lie between 1 and the set field width");
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    cache_maint_pkg::maint_op_e decoded_op;
    cache_maint_pkg::issue_state_e state_reg;
    cache_maint_pkg::queued_op_s head_op;
    logic [QW-1:0] head_raw;
    logic [31:0] ccr_reg;
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic mapped;
    logic take;
    logic priv_ok;
    logic push;
    logic pop;
    logic done_seen;
    logic [1:0] outstanding_reg;

    // Address decode; reserved gap and branch predictor stub are mapped but do nothing
    always_comb begin
        decoded_op = cache_maint_pkg::OP_NONE;
        mapped = 1'b1;
        unique case (i_bus_req.addr)
            cache_maint_pkg::ICACHE_INVALIDATE_ALL_ADDR:
                decoded_op = cache_maint_pkg::OP_IC_INV_ALL; // see RULE_02
            cache_maint_pkg::ICACHE_INVALIDATE_BY_ADDRESS_POU_ADDR:
                decoded_op = cache_maint_pkg::OP_IC_INV_ADDR_POU; // see RULE_05
            cache_maint_pkg::DCACHE_INVALIDATE_BY_ADDRESS_POC_ADDR:
                decoded_op = cache_maint_pkg::OP_DC_INV_ADDR_POC; // see RULE_06
            cache_maint_pkg::DCACHE_INVALIDATE_BY_SET_WAY_ADDR:
                decoded_op = cache_maint_pkg::OP_DC_INV_SET_WAY; // see RULE_09
            cache_maint_pkg::DCACHE_CLEAN_BY_ADDRESS_POU_ADDR:
                decoded_op = cache_maint_pkg::OP_DC_CLEAN_ADDR_POU; // see RULE_07
            cache_maint_pkg::DCACHE_CLEAN_BY_ADDRESS_POC_ADDR:
                decoded_op = cache_maint_pkg::OP_DC_CLEAN_ADDR_POC; // see RULE_07
            cache_maint_pkg::DCACHE_CLEAN_BY_SET_WAY_ADDR:
                decoded_op = cache_maint_pkg::OP_DC_CLEAN_SET_WAY; // see RULE_09
            cache_maint_pkg::DCACHE_FLUSH_BY_ADDRESS_POC_ADDR:
                decoded_op = cache_maint_pkg::OP_DC_FLUSH_ADDR_POC; // see RULE_08
            cache_maint_pkg::DCACHE_FLUSH_BY_SET_WAY_ADDR:
                decoded_op = cache_maint_pkg::OP_DC_FLUSH_SET_WAY; // see RULE_09
            cache_maint_pkg::BRANCH_PREDICTOR_INVALIDATE_STUB_ADDR:
                decoded_op = cache_maint_pkg::OP_NONE; // see RULE_03
            cache_maint_pkg::RESERVED_GAP_ADDR,
            cache_maint_pkg::CORE_CONFIG_CONTROL_ADDR:
                decoded_op = cache_maint_pkg::OP_NONE;
            default:
                mapped = 1'b0;
        endcase
    end

    // Only privileged stores reach the queue; reads never start an operation
    assign take = i_bus_req.valid && o_bus_ready;
    assign priv_ok = i_bus_req.privileged && mapped; // see RULE_01
    assign push = take && priv_ok && i_bus_req.write
        && (decoded_op != cache_maint_pkg::OP_NONE); // see RULE_01
    assign pop = (state_reg == cache_maint_pkg::ST_IDLE) && (count_reg != '0);
    assign done_seen = (state_reg == cache_maint_pkg::ST_WAIT) && i_cmd_done;

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Register answer one cycle after the access; every read of this space except the core control register returns zero
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_rsp <= '0;
        end else begin
            o_bus_rsp.valid <= take;
            o_bus_rsp.fault <= take && !priv_ok; // see RULE_01
            o_bus_rsp.rdata <= cache_maint_pkg::READ_ZERO; // see RULE_04
            if (take && priv_ok && !i_bus_req.write
                    && i_bus_req.addr == cache_maint_pkg::CORE_CONFIG_CONTROL_ADDR) begin
                o_bus_rsp.rdata <= ccr_reg;
            end
        end
    end

    // Cache enables; other bits of the control word are kept at zero
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ccr_reg <= cache_maint_pkg::CORE_CONFIG_CONTROL_RESET;
            o_dcache_enable <= 1'b0;
            o_icache_enable <= 1'b0;
        end else if (take && priv_ok && i_bus_req.write
                && i_bus_req.addr == cache_maint_pkg::CORE_CONFIG_CONTROL_ADDR) begin
            ccr_reg <= i_bus_req.wdata & cache_maint_pkg::CORE_CONFIG_CONTROL_MASK;
            o_dcache_enable <= i_bus_req.wdata[cache_maint_pkg::DCACHE_ENABLE_BIT]; // see RULE_14
            o_icache_enable <= i_bus_req.wdata[cache_maint_pkg::ICACHE_ENABLE_BIT]; // see RULE_14
        end
    end

    // Queue bookkeeping; a full queue stalls the core rather than dropping an operation
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            o_bus_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            o_bus_ready <= (count_next != DEPTH_COUNT);
        end
    end

    cache_op_queue_mem #(
        .WIDTH(QW),
        .DEPTH(QUEUE_DEPTH),
        .AW(AW)
    ) u_queue (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_wr_en(push),
        .i_wr_addr(wr_ptr_reg),
        .i_wr_data({decoded_op, i_bus_req.wdata}),
        .i_rd_en(pop),
        .i_rd_addr(rd_ptr_reg),
        .o_rd_data(head_raw)
    );

    assign head_op = cache_maint_pkg::queued_op_s'(head_raw);

    // One operation in flight at a time, so completions follow issue order
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= cache_maint_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                cache_maint_pkg::ST_IDLE: begin
                    if (pop) begin
                        state_reg <= cache_maint_pkg::ST_FETCH;
                    end
                end
                cache_maint_pkg::ST_FETCH: begin
                    state_reg <= cache_maint_pkg::ST_ISSUE;
                end
                cache_maint_pkg::ST_ISSUE: begin
                    if (i_cmd_ready) begin
                        state_reg <= cache_maint_pkg::ST_WAIT; // see RULE_19
                    end
                end
                cache_maint_pkg::ST_WAIT: begin
                    if (i_cmd_done) begin
                        state_reg <= cache_maint_pkg::ST_IDLE; // see RULE_19
                    end
                end
            endcase
        end
    end

    // Command build: set index uses the low bits of the field, way the top two bits
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cmd_valid <= 1'b0;
            o_cmd <= '0;
        end else if (state_reg == cache_maint_pkg::ST_FETCH) begin
            o_cmd_valid <= 1'b1;
            o_cmd.kind <= head_op.kind;
            o_cmd.target_virtual_address <= head_op.operand; // see RULE_04
            o_cmd.set <= '0;
            o_cmd.way <= '0;
            if (head_op.kind == cache_maint_pkg::OP_DC_INV_SET_WAY
                    || head_op.kind == cache_maint_pkg::OP_DC_CLEAN_SET_WAY
                    || head_op.kind == cache_maint_pkg::OP_DC_FLUSH_SET_WAY) begin
                o_cmd.set <= head_op.operand[cache_maint_pkg::SET_LSB +:
                    cache_maint_pkg::SET_FIELD_BITS] & SET_MASK; // see RULE_10 see RULE_12
                o_cmd.way <= head_op.operand[cache_maint_pkg::WAY_LSB +:
                    cache_maint_pkg::WAY_FIELD_BITS]; // see RULE_11
            end
        end else if (o_cmd_valid && i_cmd_ready) begin
            o_cmd_valid <= 1'b0;
        end
    end

    // Faults arrive after the store retired; a miss answers with no error (see RULE_21)
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_fault_a <= 1'b0;
            o_hard_fault_b <= 1'b0;
        end else begin
            o_bus_fault_a <= done_seen && i_cmd_error && i_bus_fault_handler_en; // see RULE_18
            o_hard_fault_b <= done_seen && i_cmd_error && !i_bus_fault_handler_en; // see RULE_18
        end
    end

    // Drained means every earlier operation has completed, which a data barrier waits on
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ops_drained <= 1'b1;
        end else begin
            o_ops_drained <= (count_next == '0) && !push && !pop
                && (state_reg == cache_maint_pkg::ST_IDLE); // see RULE_19
        end
    end

    // Helper: commands accepted by the arrays but not yet done
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            outstanding_reg <= '0;
        end else begin
            outstanding_reg <= outstanding_reg + 2'((o_cmd_valid && i_cmd_ready) ? 1 : 0)
                - 2'(done_seen ? 1 : 0);
        end
    end

    a_unpriv_faults: // see RULE_01
    assert property (take && !i_bus_req.privileged
        |-> !push ##1 (o_bus_rsp.valid && o_bus_rsp.fault))
        else $error("unprivileged access did not fault");

    a_inv_all_queued: // see RULE_02
    assert property (take && i_bus_req.privileged && i_bus_req.write
        && i_bus_req.addr == cache_maint_pkg::ICACHE_INVALIDATE_ALL_ADDR
        |-> push && decoded_op == cache_maint_pkg::OP_IC_INV_ALL)
        else $error("invalidate-all write not queued");

    a_bp_stub_inert: // see RULE_03
    assert property (take
        && i_bus_req.addr == cache_maint_pkg::BRANCH_PREDICTOR_INVALIDATE_STUB_ADDR
        |-> !push ##1 (o_bus_rsp.rdata == cache_maint_pkg::READ_ZERO))
        else $error("branch predictor stub not inert");

    a_maint_reads_zero: // see RULE_04
    assert property (take && !i_bus_req.write
        && i_bus_req.addr != cache_maint_pkg::CORE_CONFIG_CONTROL_ADDR
        |=> o_bus_rsp.valid && o_bus_rsp.rdata == cache_maint_pkg::READ_ZERO)
        else $error("maintenance register read not zero");

    a_setway_fields: // see RULE_10
    assert property ($rose(o_cmd_valid) && o_cmd.kind == cache_maint_pkg::OP_DC_CLEAN_SET_WAY
        |-> o_cmd.way == o_cmd.target_virtual_address[31:30]
        && o_cmd.set == (o_cmd.target_virtual_address[13:5] & SET_MASK))
        else $error("set/way fields decoded wrongly");

    a_single_flight: // see RULE_19
    assert property ($rose(o_cmd_valid) |-> outstanding_reg == 2'b00)
        else $error("command issued before previous one completed");

    a_fault_routed: // see RULE_18
    assert property (done_seen && i_cmd_error && i_bus_fault_handler_en
        |=> o_bus_fault_a && !o_hard_fault_b)
        else $error("handled maintenance fault escalated");

    a_miss_silent: // see RULE_21
    assert property (done_seen && !i_cmd_error |=> !o_bus_fault_a && !o_hard_fault_b)
        else $error("clean completion raised a fault");

    a_enable_bits: // see RULE_14
    assert property (take && i_bus_req.privileged && i_bus_req.write
        && i_bus_req.addr == cache_maint_pkg::CORE_CONFIG_CONTROL_ADDR
        |=> o_dcache_enable == $past(i_bus_req.wdata[cache_maint_pkg::DCACHE_ENABLE_BIT])
        && o_icache_enable == $past(i_bus_req.wdata[cache_maint_pkg::ICACHE_ENABLE_BIT]))
        else $error("cache enable bits not taken");

    a_drain_bound: // see RULE_19
    assert property (push ##1 (!push && !i_bus_req.valid)[*3] |-> !o_ops_drained)
        else $error("drained reported with work pending");

    a_fault_escalated: // see RULE_18
    assert property (done_seen && i_cmd_error && !i_bus_fault_handler_en
        |=> o_hard_fault_b && !o_bus_fault_a)
        else $error("unhandled maintenance fault not escalated");

    a_full_stalls: // see RULE_19
    assert property (count_reg == DEPTH_COUNT |-> !o_bus_ready)
        else $error("full queue still accepting stores");

    c_setway_issue: cover property ($rose(o_cmd_valid)
        && o_cmd.kind == cache_maint_pkg::OP_DC_FLUSH_SET_WAY);
    c_bus_fault: cover property (o_bus_fault_a);
    c_queue_full: cover property (!o_bus_ready);
    c_unpriv: cover property (o_bus_rsp.valid && o_bus_rsp.fault);
    c_escalated: cover property (o_hard_fault_b);

endmodule

// ### design/cache_maint_pkg.sv
// Constants, field layouts and carrier types for the L1 cache maintenance block.
// Assumes a single 40 MHz processor clock and word-wide private peripheral region accesses.
package cache_maint_pkg;

    // Register addresses in the private peripheral region
    localparam logic [31:0] ICACHE_INVALIDATE_ALL_ADDR = 32'he000ef50;
    localparam logic [31:0] RESERVED_GAP_ADDR = 32'he000ef54;
    localparam logic [31:0] ICACHE_INVALIDATE_BY_ADDRESS_POU_ADDR = 32'he000ef58;
    localparam logic [31:0] DCACHE_INVALIDATE_BY_ADDRESS_POC_ADDR = 32'he000ef5c;
    localparam logic [31:0] DCACHE_INVALIDATE_BY_SET_WAY_ADDR = 32'he000ef60;
    localparam logic [31:0] DCACHE_CLEAN_BY_ADDRESS_POU_ADDR = 32'he000ef64;
    localparam logic [31:0] DCACHE_CLEAN_BY_ADDRESS_POC_ADDR = 32'he000ef68;
    localparam logic [31:0] DCACHE_CLEAN_BY_SET_WAY_ADDR = 32'he000ef6c;
    localparam logic [31:0] DCACHE_FLUSH_BY_ADDRESS_POC_ADDR = 32'he000ef70;
    localparam logic [31:0] DCACHE_FLUSH_BY_SET_WAY_ADDR = 32'he000ef74;
    localparam logic [31:0] BRANCH_PREDICTOR_INVALIDATE_STUB_ADDR = 32'he000ef78;
    localparam logic [31:0] CORE_CONFIG_CONTROL_ADDR = 32'he000ed14;

    // Field positions
    localparam int DCACHE_ENABLE_BIT = 16;
    localparam int ICACHE_ENABLE_BIT = 17;
    localparam int SET_LSB = 5;
    localparam int SET_FIELD_BITS = 9;
    localparam int WAY_LSB = 30;
    localparam int WAY_FIELD_BITS = 2;

    // Reset and read values
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam logic [31:0] CORE_CONFIG_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] CORE_CONFIG_CONTROL_MASK = 32'h0003_0000;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_IC_INV_ALL = 4'h1,
        OP_IC_INV_ADDR_POU = 4'h2,
        OP_DC_INV_ADDR_POC = 4'h3,
        OP_DC_INV_SET_WAY = 4'h4,
        OP_DC_CLEAN_ADDR_POU = 4'h5,
        OP_DC_CLEAN_ADDR_POC = 4'h6,
        OP_DC_CLEAN_SET_WAY = 4'h7,
        OP_DC_FLUSH_ADDR_POC = 4'h8,
        OP_DC_FLUSH_SET_WAY = 4'h9
    } maint_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_ISSUE = 2'b10,
        ST_WAIT = 2'b11
    } issue_state_e;

    // Register access from the core's load/store unit
    typedef struct packed {
        logic valid;
        logic write;
        logic privileged;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [31:0] rdata;
    } bus_rsp_s;

    // Operation as held in the in-order queue
    typedef struct packed {
        maint_op_e kind;
        logic [31:0] operand;
    } queued_op_s;

    // Command to the cache arrays
    typedef struct packed {
        maint_op_e kind;
        logic [31:0] target_virtual_address;
        logic [SET_FIELD_BITS-1:0] set;
        logic [WAY_FIELD_BITS-1:0] way;
    } cache_cmd_s;

endpackage

// ### design/cache_op_queue_mem.sv
// Small storage array for queued maintenance operations.
// Assumes the owner keeps the pointers and never reads and writes one slot in a cycle.
`timescale 1ns/100ps
module cache_op_queue_mem #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Array has no reset; only slots that were written are ever read
    always_ff @(posedge i_clk_sys) begin
        if (i_wr_en) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end

    // Registered read port keeps the array off the command path
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end

endmodule

// ### tb/l1_cache_maintenance_ops_tb.sv
// Self-checking bench for the L1 cache maintenance register block.
// Assumes the bench plays both the load/store unit and the cache arrays.
`timescale 1ns/100ps
module l1_cache_maintenance_ops_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    cache_maint_pkg::bus_req_s i_bus_req = '0;
    cache_maint_pkg::bus_rsp_s o_bus_rsp;
    cache_maint_pkg::cache_cmd_s o_cmd;
    logic o_bus_ready, o_cmd_valid, o_bus_fault_a, o_hard_fault_b;
    logic o_ops_drained, o_dcache_enable, o_icache_enable;
    logic i_cmd_ready = 1'b0;
    logic i_cmd_done = 1'b0;
    logic i_cmd_error = 1'b0;
    logic i_bus_fault_handler_en = 1'b1;
    logic err_next = 1'b0;
    logic saw_full = 1'b0;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int stall = 0;
    int n_async = 0;
    int n_hard = 0;
    cache_maint_pkg::cache_cmd_s exp_q[$];
    cache_maint_pkg::cache_cmd_s got_q[$];

    l1_cache_maintenance_ops uut (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_bus_req(i_bus_req),
        .o_bus_ready(o_bus_ready), .o_bus_rsp(o_bus_rsp), .o_cmd_valid(o_cmd_valid),
        .o_cmd(o_cmd), .i_cmd_ready(i_cmd_ready), .i_cmd_done(i_cmd_done),
        .i_cmd_error(i_cmd_error), .i_bus_fault_handler_en(i_bus_fault_handler_en),
        .o_bus_fault_a(o_bus_fault_a), .o_hard_fault_b(o_hard_fault_b),
        .o_ops_drained(o_ops_drained), .o_dcache_enable(o_dcache_enable),
        .o_icache_enable(o_icache_enable));

    // 40 MHz processor clock
    always #12.5 i_clk_sys = ~i_clk_sys;

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("Counts: checked=%0d failed=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Operation code a store to this address should queue, zero for none
    function automatic logic [3:0] kind_of(input logic [31:0] a);
        if (a == 32'he000ef50)
            return 4'h1;
        if (a >= 32'he000ef58 && a <= 32'he000ef74)
            return 4'((a - 32'he000ef58) >> 2) + 4'h2;
        return 4'h0;
    endfunction

    // One register access; request held until taken, answer checked next cycle
    task automatic access(input logic wr, input logic pr, input logic [31:0] a,
                          input logic [31:0] d, input logic flt, input logic [31:0] rd);
        logic [3:0] k;
        logic sw;
        k = kind_of(a);
        sw = (k == 4'h4 || k == 4'h7 || k == 4'h9);
        @(posedge i_clk_sys);
        i_bus_req <= {1'b1, wr, pr, a, d};
        @(negedge i_clk_sys);
        // A stuck ready is caught by the cycle ceiling
        while (o_bus_ready !== 1'b1)
            @(negedge i_clk_sys);
        @(posedge i_clk_sys);
        i_bus_req.valid <= 1'b0;
        @(negedge i_clk_sys);
        check(o_bus_rsp.valid, 1'b1);
        check(o_bus_rsp.fault, flt);
        if (!wr)
            check(o_bus_rsp.rdata, rd);
        if (wr && pr && !flt && k != 4'h0) begin
            // Reserved set/way bits must not leak into set or way
            exp_q.push_back({k, d, sw ? d[13:5] : 9'h0, sw ? d[31:30] : 2'h0});
            check(o_ops_drained, 1'b0);
        end
    endtask

    // Waits for the issuer to empty, then compares commands in store order
    task automatic drain(input string name);
        while (o_ops_drained !== 1'b1)
            @(negedge i_clk_sys);
        check(got_q.size(), exp_q.size());
        while (got_q.size() > 0 && exp_q.size() > 0)
            check(got_q.pop_front(), exp_q.pop_front());
        got_q.delete();
        exp_q.delete();
        $display("Test %s done", name);
    endtask

    // Cache array stand-in: optional stall before accepting, done two cycles later
    initial begin
        forever begin
            @(negedge i_clk_sys);
            if (o_cmd_valid === 1'b1) begin
                got_q.push_back(o_cmd);
                repeat (stall) @(posedge i_clk_sys);
                @(posedge i_clk_sys);
                i_cmd_ready <= 1'b1;
                @(posedge i_clk_sys);
                i_cmd_ready <= 1'b0;
                repeat (2) @(posedge i_clk_sys);
                i_cmd_done <= 1'b1;
                i_cmd_error <= err_next;
                @(posedge i_clk_sys);
                i_cmd_done <= 1'b0;
                i_cmd_error <= 1'b0;
            end
        end
    end

    // Fault pulse counting and hang guard
    always @(negedge i_clk_sys) begin
        cycles++;
        if (o_bus_fault_a === 1'b1)
            n_async++;
        if (o_hard_fault_b === 1'b1)
            n_hard++;
        if (o_bus_ready === 1'b0)
            saw_full = 1'b1;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(negedge i_clk_sys);
        check({o_bus_ready, o_ops_drained, o_cmd_valid}, 3'b110);
        check({o_dcache_enable, o_icache_enable}, 2'b00);
        // Every location once, odd slots with all reserved bits set and way 3
        for (int i = 0; i < 11; i++)
            access(1'b1, 1'b1, 32'he000ef50 + 4 * i, i[0] ? 32'hffff_ffff : 32'h4000_0020,
                   1'b0, 32'h0);
        for (int i = 0; i < 11; i++)
            access(1'b0, 1'b1, 32'he000ef50 + 4 * i, 32'h0, 1'b0, 32'h0);
        drain("all registers");
        check(n_async + n_hard, 0);
        // Slow arrays fill the queue so the bus must wait
        // Set indices stay inside the reported geometry
        stall = 30;
        for (int i = 0; i < 6; i++)
            access(1'b1, 1'b1, 32'he000ef6c, {i[1:0], 16'h0, 9'(i + 500), 5'h0}, 1'b0, 32'h0);
        stall = 0;
        drain("queue full");
        check(saw_full, 1'b1);
        // Array errors with the handler on, then off
        err_next = 1'b1;
        access(1'b1, 1'b1, 32'he000ef5c, 32'h2000_0100, 1'b0, 32'h0);
        drain("fault handled");
        check({n_async, n_hard}, {32'd1, 32'd0});
        @(posedge i_clk_sys);
        i_bus_fault_handler_en <= 1'b0;
        access(1'b1, 1'b1, 32'he000ef68, 32'h2000_0140, 1'b0, 32'h0);
        drain("fault escalated");
        check({n_async, n_hard}, {32'd1, 32'd1});
        err_next = 1'b0;
        @(posedge i_clk_sys);
        i_bus_fault_handler_en <= 1'b1;
        // Unprivileged and unmapped accesses queue nothing
        access(1'b1, 1'b0, 32'he000ef50, 32'h0, 1'b1, 32'h0);
        access(1'b0, 1'b0, 32'he000ef58, 32'h0, 1'b1, 32'h0);
        access(1'b1, 1'b1, 32'he000ef7c, 32'h0, 1'b1, 32'h0);
        drain("refusals");
        // Cache enable bits in the core control register
        access(1'b1, 1'b1, 32'he000ef50, 32'h0, 1'b0, 32'h0);
        drain("invalidate before enable");
        access(1'b1, 1'b1, 32'he000ed14, 32'hffff_ffff, 1'b0, 32'h0);
        check({o_dcache_enable, o_icache_enable}, 2'b11);
        access(1'b0, 1'b1, 32'he000ed14, 32'h0, 1'b0, 32'h0003_0000);
        access(1'b1, 1'b1, 32'he000ed14, 32'h0001_0000, 1'b0, 32'h0);
        check({o_dcache_enable, o_icache_enable}, 2'b10);
        drain("control");
        // Clean before the data cache goes off
        access(1'b1, 1'b1, 32'he000ef6c, 32'hc000_3fe0, 1'b0, 32'h0);
        drain("clean before disable");
        access(1'b1, 1'b1, 32'he000ed14, 32'h0, 1'b0, 32'h0);
        check({o_dcache_enable, o_icache_enable}, 2'b00);
        conclude();
    end
endmodule
